// ==== rtl/tev_pkg.sv ====
// tev_pkg: shared constants for the transient event detector
package tev_pkg;
  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam logic [5:0]  IDX_CFG      = 6'h1D;  // transient config
  localparam logic [5:0]  IDX_SRC      = 6'h1E;  // transient_event_status
  localparam logic [5:0]  IDX_THS      = 6'h1F;  // transient_threshold_cfg
  localparam logic [5:0]  IDX_CNT      = 6'h20;  // transient_debounce_count
  localparam logic [5:0]  IDX_CTRL     = 6'h30;  // range, rate and power mode
  localparam logic [5:0]  IDX_AXTHS0   = 6'h31;  // per-axis thresholds x,y,z
  localparam logic [5:0]  IDX_AXTHS_EN = 6'h34;  // per-axis threshold override
  localparam logic [5:0]  IDX_IRQ_ST   = 6'h38;  // sticky interrupt status
  localparam logic [5:0]  IDX_IRQ_MSK  = 6'h39;  // interrupt mask
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CFG_BYP  = 0;  // filter bypass
  localparam int CFG_EN0  = 1;  // axis enables at 1..3
  localparam int CFG_ELE  = 4;  // latch enable
  localparam int SRC_EA   = 6;  // any axis active; axis n pol 2n, flag 2n+1
  localparam int THS_DBM  = 7;  // debounce mode select
  localparam int CTRL_LN  = 0;  // low-noise range limit
  localparam int CTRL_RANGE = 1;  // full_scale_select, 2 bits
  localparam int CTRL_ODR = 3;  // data rate code, 3 bits
  localparam int CTRL_PM  = 6;  // power mode, 2 bits
  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_REG  = 8'h00;
  localparam logic [1:0]  PM_NORM  = 2'h0;
  localparam logic [1:0]  PM_LP_LN = 2'h1;
  localparam logic [1:0]  PM_HIRES = 2'h2;
  localparam logic [1:0]  PM_LOWP  = 2'h3;
  // ------------------------------------------------------------
  // scaling: magnitudes in 0.244 mg units (2 g range lsb)
  // ------------------------------------------------------------
  localparam int unsigned THS_MG    = 63;   // threshold weight, mg
  localparam int unsigned LSB_UG    = 244;  // finest lsb, ug
  localparam logic [16:0] THS_UNIT  = 17'((THS_MG * 1000) / LSB_UG);
  localparam logic [16:0] LN_MAX    = 17'h04000;  // 4 g
  // ------------------------------------------------------------
  // timing: shortest debounce step
  // ------------------------------------------------------------
  localparam real         STEP_BASE_MS  = 1.25;
  localparam real         CLK_MHZ       = 125.0;
  localparam int unsigned STEP_BASE_CYC = int'(STEP_BASE_MS * 1000.0 * CLK_MHZ);
  // bus handshake states
  typedef enum logic {BUS_IDLE, BUS_ANSWER} tev_bus_t;
endpackage : tev_pkg

// ==== rtl/tev_axis_if.sv ====
// tev_axis_if: per-axis link between the control core and a debouncer
`timescale 1ns/1ps
`default_nettype none
interface tev_axis_if;
  logic       step;    // debounce step tick
  logic       cond;    // condition met in the current period
  logic       mode;    // 1 clears, 0 decrements when not met
  logic [7:0] target;  // debounce_target_count
  logic       fire;    // one-cycle event pulse
  logic [7:0] count;   // running debounce count
  modport ctl (output step, cond, mode, target, input fire, count);
  modport det (input step, cond, mode, target, output fire, count);
endinterface : tev_axis_if
`default_nettype wire

// ==== rtl/tev_axis_debounce.sv ====
// tev_axis_debounce: debounce counter for one axis
`timescale 1ns/1ps
`default_nettype none
module tev_axis_debounce
  import tev_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  tev_axis_if.det   ax
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [7:0] count;       // current count
  logic [7:0] next_count;  // count after this step
  logic       fire;        // registered event pulse

  // ------------------------------------------------------------
  // step rule: count up while met, else clear or decrement
  // ------------------------------------------------------------
  always_comb
  begin
    next_count = count;
    if (ax.step)
    begin
      if (ax.cond)
        next_count = (count < ax.target) ? count + 8'h01 : ax.target;  // R11 R18
      else if (ax.mode)
        next_count = 8'h00;  // R8
      else if (count != 8'h00)
        next_count = count - 8'h01;  // R7 R18
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      count <= 8'h00;
    else
      count <= next_count;
  end

  // event once the full target has been reached while met
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fire <= 1'b0;
    else
      fire <= ax.step & ax.cond & (next_count >= ax.target);  // R2
  end

  assign ax.count = count;
  assign ax.fire  = fire;

  clear_mode_a : assert property (ax.step && !ax.cond && ax.mode |=> count == 8'h00)  // R8
    else $error("debounce count not cleared");
  dec_mode_a : assert property (ax.step && !ax.cond && !ax.mode && count != 8'h00
    |=> count == $past(count) - 8'h01)  // R7
    else $error("debounce count not decremented");
  fire_cause_a : assert property (fire |-> $past(ax.step) && $past(ax.cond))  // R2
    else $error("event without a met step");
  count_hold_a : assert property (!ax.step |=> count == $past(count))  // R18
    else $error("count moved without a step");
endmodule : tev_axis_debounce
`default_nettype wire

// ==== rtl/tev_step_timer.sv ====
// tev_step_timer: debounce step tick from rate and power mode
`timescale 1ns/1ps
`default_nettype none
module tev_step_timer
  import tev_pkg::*;
#(
  parameter int unsigned BASE_CYC = STEP_BASE_CYC
)(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] odr,
  input  wire logic [1:0] pmode,
  output logic            step
);
  logic [31:0] cnt;     // cycles into the current step
  logic [31:0] period;  // step length in cycles
  logic [7:0]  mult;    // step as a multiple of 1.25 ms

  // ------------------------------------------------------------
  // step length table
  // ------------------------------------------------------------
  always_comb
  begin
    mult = 8'h10;
    case (pmode)
      PM_HIRES: mult = (odr == 3'h0) ? 8'h01 : 8'h02;  // R13
      PM_LP_LN: mult = (odr >= 3'h5) ? 8'h40 : 8'(1 << odr);  // R13
      PM_LOWP:  mult = (odr >= 3'h6) ? 8'h80 :
                       (odr == 3'h5) ? 8'h40 : 8'(1 << odr);  // R13
      default:  mult = (odr >= 3'h4) ? 8'h10 : 8'(1 << odr);  // R12
    endcase
  end
  assign period = 32'(BASE_CYC * mult);

  // free-running step counter; a shorter new period ends the step at once
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt  <= 32'h0;
      step <= 1'b0;
    end
    else if (cnt + 32'h1 >= period)
    begin
      cnt  <= 32'h0;
      step <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + 32'h1;
      step <= 1'b0;
    end
  end
endmodule : tev_step_timer
`default_nettype wire

// ==== rtl/tev_detector.sv ====
// tev_detector: transient event detector with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] active flag is or of axis flags
// [R2] flag after threshold exceeded full debounce
// [R3] polarity zero above, one below threshold
// [R4] latch mode freezes flags and polarities
// [R5] non-latch mode keeps updating flags, polarities
// [R6] flags clear only by status read
// [R7] mode zero decrements count when unmet
// [R8] mode one clears count when unmet
// [R9] threshold seven bits at 63 mg
// [R10] low noise limits range to 4 g
// [R11] count register sets debounce steps needed
// [R12] normal step one period, max 20 ms
// [R13] high-res, low-noise and low power step lengths
// [R14] per-axis thresholds may replace common one
// [R15] only enabled axes raise flags
// [R16] bypass selects unfiltered data
// [R17] active flag drives level interrupt request; irq follows the masked sticky irq_st instead
// [R18] count saturates at target, floors zero
module tev_detector
  import tev_pkg::*;
#(
  parameter int unsigned DATA_W   = 14,            // sample width
  parameter int unsigned BASE_CYC = STEP_BASE_CYC  // cycles per 1.25 ms
)(
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic [ADDR_W-1:0]        avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     sample_valid,
  input  wire logic signed [DATA_W-1:0] filt_x,
  input  wire logic signed [DATA_W-1:0] filt_y,
  input  wire logic signed [DATA_W-1:0] filt_z,
  input  wire logic signed [DATA_W-1:0] raw_x,
  input  wire logic signed [DATA_W-1:0] raw_y,
  input  wire logic signed [DATA_W-1:0] raw_z,
  output logic                          any_axis_active_flag,
  output logic                          irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  tev_bus_t    bus_state;     // handshake state
  logic [5:0]  idx;           // word index of the access
  logic        acc;           // access completes this edge
  logic        wr_en;         // write completes this edge
  logic        rd_en;         // read completes this edge
  logic [7:0]  cfg;           // bypass, enables, latch enable
  logic [7:0]  ths;           // mode and common_threshold_value
  logic [7:0]  cnt_reg;       // debounce_target_count
  logic [7:0]  ctrl;          // low noise, full scale, rate, power
  logic [6:0]  axths [3];     // per-axis thresholds
  logic        axths_en;      // per-axis override enable
  logic [2:0]  ef;            // axis event flags
  logic [2:0]  pol;           // axis polarities
  logic        irq_st;        // sticky interrupt status
  logic        irq_msk;       // interrupt mask
  logic [7:0]  rd_mux;        // read value of the addressed register
  logic [2:0]  cond_q;        // latched comparison per axis
  logic [2:0]  pol_q;         // latched sign per axis
  logic [2:0]  fire_v;        // event pulses from debouncers
  logic [2:0]  next_ef;       // flags after clear and set
  logic [2:0]  next_pol;      // polarities after clear and set
  logic        frozen;        // latch mode holds the captured event
  logic        next_irq_st;   // interrupt status after clear and set
  logic        step;          // debounce step tick
  logic [1:0]  range_sh;      // range shift into finest units
  logic signed [DATA_W-1:0] filt_a [3];
  logic signed [DATA_W-1:0] raw_a  [3];

  assign filt_a[0] = filt_x;
  assign filt_a[1] = filt_y;
  assign filt_a[2] = filt_z;
  assign raw_a[0]  = raw_x;
  assign raw_a[1]  = raw_y;
  assign raw_a[2]  = raw_z;
  assign idx   = avs_address[7:2];
  assign acc   = (bus_state == BUS_ANSWER);
  assign wr_en = acc & avs_write & avs_byteenable[0];
  assign rd_en = acc & avs_read;
  // reserved range code is read as the widest range
  assign range_sh = (ctrl[CTRL_RANGE+:2] == 2'h3) ? 2'h2 : ctrl[CTRL_RANGE+:2];

  // ------------------------------------------------------------
  // bus handshake: one wait cycle, then the answer
  // ------------------------------------------------------------
  // read data are captured on entry to the answer cycle, so the
  // value cleared by a read is exactly the value returned
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_state       <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else
    begin
      case (bus_state)
        BUS_IDLE:
        begin
          if (avs_read || avs_write)
          begin
            bus_state       <= BUS_ANSWER;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h0, rd_mux};
          end
        end
        BUS_ANSWER:
        begin
          bus_state       <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default:
        begin
          bus_state       <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // read multiplexer; unmapped words read as zero
  always_comb
  begin
    rd_mux = 8'h00;
    case (idx)
      IDX_CFG:      rd_mux = {3'h0, cfg[4:0]};
      IDX_SRC:      rd_mux = {1'b0, |ef, ef[2], pol[2], ef[1], pol[1], ef[0], pol[0]};
      IDX_THS:      rd_mux = ths;
      IDX_CNT:      rd_mux = cnt_reg;
      IDX_CTRL:     rd_mux = ctrl;
      IDX_AXTHS0:   rd_mux = {1'b0, axths[0]};
      IDX_AXTHS0+6'h1: rd_mux = {1'b0, axths[1]};
      IDX_AXTHS0+6'h2: rd_mux = {1'b0, axths[2]};
      IDX_AXTHS_EN: rd_mux = {7'h0, axths_en};
      IDX_IRQ_ST:   rd_mux = {7'h0, irq_st};
      IDX_IRQ_MSK:  rd_mux = {7'h0, irq_msk};
      default:      rd_mux = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg      <= RST_REG;
      ths      <= RST_REG;
      cnt_reg  <= RST_REG;
      ctrl     <= RST_REG;
      axths[0] <= 7'h00;
      axths[1] <= 7'h00;
      axths[2] <= 7'h00;
      axths_en <= 1'b0;
      irq_msk  <= 1'b0;
    end
    else if (wr_en)
    begin
      case (idx)
        IDX_CFG:      cfg     <= {3'h0, avs_writedata[4:0]};
        IDX_THS:      ths     <= avs_writedata[7:0];  // R9
        IDX_CNT:      cnt_reg <= avs_writedata[7:0];  // R11
        IDX_CTRL:     ctrl    <= avs_writedata[7:0];
        IDX_AXTHS0:   axths[0] <= avs_writedata[6:0];
        IDX_AXTHS0+6'h1: axths[1] <= avs_writedata[6:0];
        IDX_AXTHS0+6'h2: axths[2] <= avs_writedata[6:0];
        IDX_AXTHS_EN: axths_en <= avs_writedata[0];
        IDX_IRQ_MSK:  irq_msk  <= avs_writedata[0];
        default:
        begin
          // writes to status or unmapped words are dropped
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // debounce step timer
  // ------------------------------------------------------------
  tev_step_timer #(
    .BASE_CYC (BASE_CYC)
  ) u_step (
    .clk     (clk),
    .sys_rst (sys_rst),
    .odr     (ctrl[CTRL_ODR+:3]),
    .pmode   (ctrl[CTRL_PM+:2]),
    .step    (step)
  );

  // ------------------------------------------------------------
  // per-axis comparison and debounce
  // ------------------------------------------------------------
  for (genvar g = 0; g < 3; g++)
  begin : g_axis
    logic signed [DATA_W-1:0] smp;   // selected sample
    logic [DATA_W:0]          absv;  // magnitude, one extra bit for -full scale
    logic [16:0]              mag;   // magnitude in finest units
    logic [16:0]              lim;   // magnitude after low-noise limit
    logic [6:0]               thv;   // threshold in use
    logic [16:0]              thr;   // threshold in finest units
    tev_axis_if               axl ();

    assign smp  = cfg[CFG_BYP] ? raw_a[g] : filt_a[g];  // R16
    assign absv = smp[DATA_W-1] ? (DATA_W+1)'(-{smp[DATA_W-1], smp}) : {1'b0, smp};
    assign mag  = 17'({2'b00, absv} << range_sh);
    assign lim  = (ctrl[CTRL_LN] && mag > LN_MAX) ? LN_MAX : mag;  // R10
    assign thv  = axths_en ? axths[g] : ths[6:0];  // R14
    assign thr  = 17'(thv * THS_UNIT);  // R9

    // compare once per sample; the result stands until the next one
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        cond_q[g] <= 1'b0;
        pol_q[g]  <= 1'b0;
      end
      else if (sample_valid)
      begin
        cond_q[g] <= lim > thr;
        pol_q[g]  <= smp[DATA_W-1];  // R3
      end
    end

    assign axl.step   = step;
    assign axl.cond   = cond_q[g] & cfg[CFG_EN0+g];  // R15
    assign axl.mode   = ths[THS_DBM];
    assign axl.target = cnt_reg;
    assign fire_v[g]  = axl.fire;

    tev_axis_debounce u_db (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ax      (axl)
    );

    axis_enable_a : assert property (fire_v[g] |-> $past(cfg[CFG_EN0+g]))  // R15
      else $error("disabled axis raised an event");
  end

  // ------------------------------------------------------------
  // event status: read clears what was returned, set wins
  // ------------------------------------------------------------
  always_comb
  begin
    next_ef  = ef;
    next_pol = pol;
    if (rd_en && idx == IDX_SRC)
    begin
      // only bits that the read returned are cleared
      next_ef  = ef & ~{avs_readdata[5], avs_readdata[3], avs_readdata[1]};  // R6
      next_pol = pol & ~{avs_readdata[4], avs_readdata[2], avs_readdata[0]};
    end
    frozen = cfg[CFG_ELE] & (|next_ef);  // R4
    if (!frozen)
    begin
      next_ef  = next_ef | fire_v;  // R2 R5
      next_pol = (next_pol & ~fire_v) | (pol_q & fire_v);  // R3 R5
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ef                   <= 3'h0;
      pol                  <= 3'h0;
      any_axis_active_flag <= 1'b0;
    end
    else
    begin
      ef                   <= next_ef;
      pol                  <= next_pol;
      any_axis_active_flag <= |next_ef;  // R1 R17
    end
  end

  // ------------------------------------------------------------
  // interrupt status, mask and level output
  // ------------------------------------------------------------
  always_comb
  begin
    next_irq_st = irq_st;
    if (rd_en && idx == IDX_IRQ_ST && avs_readdata[0])
      next_irq_st = 1'b0;
    if (!frozen && (|fire_v))
      next_irq_st = 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_st <= 1'b0;
      irq    <= 1'b0;
    end
    else
    begin
      irq_st <= next_irq_st;
      irq    <= next_irq_st & irq_msk;  // R17
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_src_read;
    // a flag set after the data were captured is not returned, so it survives
    rd_en && idx == IDX_SRC && avs_readdata[SRC_EA] && fire_v == 3'h0
      && {avs_readdata[5], avs_readdata[3], avs_readdata[1]} == ef;
  endsequence

  sequence s_flag_up;
    any_axis_active_flag;
  endsequence

  active_or_a : assert property (any_axis_active_flag == (|ef))  // R1
    else $error("active flag differs from axis flags");
  read_clear_a : assert property (s_src_read |=> ef == 3'h0 && !any_axis_active_flag)  // R6
    else $error("status read did not clear flags");
  sticky_flag_a : assert property (s_flag_up ##0 !(rd_en && idx == IDX_SRC)
    |=> any_axis_active_flag)  // R6 R17
    else $error("flag fell without a status read");
  latch_hold_a : assert property (cfg[CFG_ELE] && |ef && !(rd_en && idx == IDX_SRC)
    |=> ef == $past(ef) && pol == $past(pol))  // R4
    else $error("latched event changed");
  update_a : assert property (!cfg[CFG_ELE] && fire_v != 3'h0
    |=> (ef & $past(fire_v)) == $past(fire_v) && (pol & $past(fire_v)) == ($past(pol_q) & $past(fire_v)))  // R5 R3
    else $error("later event did not update flags");
  bus_answer_a : assert property ((avs_read || avs_write) && avs_waitrequest && bus_state == BUS_IDLE
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");
endmodule : tev_detector
`default_nettype wire

// ==== tb/tev_detector_test.sv ====
// tev_detector_test: self-checking bench for the transient event detector
`timescale 1ns/1ps
`default_nettype none
module tev_detector_test
  import tev_pkg::*;
;
  // ------------------------------------------------------------
  // clock, reset and design ports
  // ------------------------------------------------------------
  localparam int unsigned BC = 20;          // short debounce step keeps the run brief
  logic                     clk             = 1'b0;
  logic                     sys_rst         = 1'b1;
  logic [ADDR_W-1:0]        avs_address     = 8'h00;
  logic                     avs_read        = 1'b0;
  logic                     avs_write       = 1'b0;
  logic [31:0]              avs_writedata   = 32'h0;
  logic [31:0]              avs_readdata;
  logic                     avs_waitrequest;
  logic                     sample_valid    = 1'b0;
  logic signed [13:0]       filt_x          = 14'h0;
  logic signed [13:0]       filt_y          = 14'h0;
  logic signed [13:0]       filt_z          = 14'h0;
  logic signed [13:0]       raw_x           = 14'h0;
  logic signed [13:0]       raw_y           = 14'h0;
  logic signed [13:0]       raw_z           = 14'h0;
  logic                     any_axis_active_flag;
  logic                     irq;
  logic [31:0]              seed            = 32'h00017234;  // fixed seed, repeatable run
  int                       n_errors        = 0;
  int                       samples_checked = 0;
  // clock at 125 MHz
  always #4 clk = ~clk;
  // a new sample every other cycle
  always @(posedge clk) sample_valid <= ~sample_valid;
  tev_detector #(.DATA_W(14), .BASE_CYC(BC)) dut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
    .filt_x(filt_x), .filt_y(filt_y), .filt_z(filt_z), .raw_x(raw_x), .raw_y(raw_y),
    .raw_z(raw_z), .any_axis_active_flag(any_axis_active_flag), .irq(irq));
  // ------------------------------------------------------------
  // verdict, compare and bus tasks
  // ------------------------------------------------------------
  task automatic final_report;
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // one compare for every byte-wide result
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // avalon-mm access: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write     <= wr;
    avs_read      <= ~wr;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // a slave that never answers ends the run
    if (n >= 50)
    begin
      n_errors++;
      final_report();
    end
  endtask : bus
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] dummy;
    bus(1'b1, idx, d, dummy);
  endtask : wr
  task automatic rd_chk(input string what, input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk(what, exp, d);
  endtask : rd_chk
  // wait for the active flag; a flag that never comes ends the run
  task automatic wait_flag(output int t);
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (any_axis_active_flag !== 1'b1 && t < 400);
    chk("active flag", 8'h01, {7'h0, any_axis_active_flag});
    if (any_axis_active_flag !== 1'b1)
      final_report();
  endtask : wait_flag
  // ------------------------------------------------------------
  // stimulus and expectation helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // x fires first, positive; z comes later, negative, and shows only without latching
  function automatic logic [7:0] exp_src(input bit latch);
    logic [7:0] v;
    v = 8'h00;
    v[1] = 1'b1;
    v[4] = ~latch;
    v[5] = ~latch;
    v[SRC_EA] = 1'b1;
    return v;
  endfunction : exp_src
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    int t;
    logic signed [13:0] mag;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk("status reset", IDX_SRC, RST_REG);
    rd_chk("threshold reset", IDX_THS, RST_REG);
    rd_chk("count reset", IDX_CNT, RST_REG);
    rd_chk("unmapped", 6'h3F, 8'h00);
    wr(IDX_SRC, 8'hFF);
    rd_chk("status after write", IDX_SRC, 8'h00);
    wr(IDX_CNT, 8'h03);
    rd_chk("count", IDX_CNT, 8'h03);
    // latching on with decrement mode, then off with clear mode
    for (int ele = 1; ele >= 0; ele--)
    begin
      wr(IDX_THS, {~ele[0], 7'h04});
      // the latching pass reads unfiltered data, the other filtered data
      wr(IDX_CFG, {3'h0, ele[0], 3'b101, ele[0]});
      wr(IDX_IRQ_MSK, {7'h0, ele[0]});
      seed = lfsr_next(seed);
      // magnitude beyond four threshold counts of 258 units; the unused source stays zero
      mag = 14'(32'h44C + seed % 32'hFA0);
      filt_x <= ele[0] ? 14'h0 : mag;
      raw_x  <= ele[0] ? mag : 14'h0;
      filt_y <= -14'sh1770;
      raw_y  <= -14'sh1770;
      wait_flag(t);
      chk("debounce length", 8'h01, {7'h0, t >= 2 * BC && t <= 3 * BC + 4});
      @(posedge clk);
      chk("irq masked", {7'h0, ele[0]}, {7'h0, irq});
      filt_x <= 14'h0;
      raw_x  <= 14'h0;
      filt_z <= ele[0] ? 14'h0 : -mag;
      raw_z  <= ele[0] ? -mag : 14'h0;
      repeat (8 * BC) @(posedge clk);
      filt_z <= 14'h0;
      raw_z  <= 14'h0;
      repeat (2 * BC) @(posedge clk);
      rd_chk("status", IDX_SRC, exp_src(ele[0]));
      rd_chk("status cleared", IDX_SRC, 8'h00);
      chk("flag cleared", 8'h00, {7'h0, any_axis_active_flag});
      rd_chk("irq status", IDX_IRQ_ST, 8'h01);
      repeat (2) @(posedge clk);
      chk("irq cleared", 8'h00, {7'h0, irq});
    end
    // 8 g range, high resolution at the second rate: a step is two base periods
    wr(IDX_THS, 8'hC1);
    wr(IDX_CTRL, {PM_HIRES, 3'h1, 2'h2, 1'b1});
    filt_x <= 14'h1F40;
    repeat (8 * BC) @(posedge clk);
    // four times 8000 passes 65 counts only while the 4 g clamp is off
    rd_chk("low noise clamp", IDX_SRC, 8'h00);
    wr(IDX_AXTHS0, 8'h7F);
    wr(IDX_AXTHS_EN, 8'h01);
    wr(IDX_CTRL, {PM_HIRES, 3'h1, 2'h2, 1'b0});
    repeat (8 * BC) @(posedge clk);
    rd_chk("axis threshold", IDX_SRC, 8'h00);
    wr(IDX_AXTHS_EN, 8'h00);
    wait_flag(t);
    chk("hires step", 8'h01, {7'h0, t >= 4 * BC && t <= 6 * BC + 4});
    rd_chk("common threshold", IDX_SRC, 8'h42);
    final_report();
  end
endmodule : tev_detector_test
`default_nettype wire
